// ==== src/fan_opoint_ramp.sv ====
// top: operating point capture, dynamic enables and fan duty ramping
//
// Function
// RULE1: alert copies remote 2 temp when enabled
// RULE2: alert copies local temp when enabled
// RULE3: alert copies remote 1 temp when enabled
// RULE4: processor pulls alert low on thermal trip
// RULE5: bit 7 enables remote 2 dynamic minimum
// RULE6: bit 6 enables local dynamic minimum
// RULE7: bit 5 enables remote 1 dynamic minimum
// RULE8: cleared enable leaves minimum temperature alone
// RULE9: set enable lets minimum track zone
// RULE10: acoustic reg 1 bit 3 ramps output 1
// RULE11: acoustic reg 2 bit 7 ramps output 2
// RULE12: acoustic reg 2 bit 3 ramps output 3
// RULE13: drive period is 255 equal slots
// RULE14: step is 1,2,3,5,8,12,24,48 slots
// RULE15: ramping computes new target each update
// RULE16: target above previous adds one step
// RULE17: target below previous subtracts one step
// RULE18: stepped result becomes next previous duty
// RULE19: each output ramps on its own
// RULE20: no ramping applies target at once
// RULE21: three bit codes map to step sizes
// RULE22: slow bit divides ramp rate by four
// RULE23: equal target holds, duty stays 0..255
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module fan_opoint_ramp #(
	parameter int SLOW_DIV = fan_pkg::SLOW_FACTOR
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fan_pkg::ADDR_W-1:0] paddr,
	input wire logic [fan_pkg::DATA_W-1:0] pwdata,
	output logic [fan_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic thermalAlertN,
	input wire logic [7:0] tempRemote1,
	input wire logic [7:0] tempLocal,
	input wire logic [7:0] tempRemote2,
	input wire logic [7:0] targetDuty1,
	input wire logic [7:0] targetDuty2,
	input wire logic [7:0] targetDuty3,
	input wire logic dutyUpdate1,
	input wire logic dutyUpdate2,
	input wire logic dutyUpdate3,
	output logic [7:0] opointRemote1,
	output logic [7:0] opointLocal,
	output logic [7:0] opointRemote2,
	output logic dynMinEnRemote1,
	output logic dynMinEnLocal,
	output logic dynMinEnRemote2,
	output logic [7:0] fanDuty1,
	output logic [7:0] fanDuty2,
	output logic [7:0] fanDuty3,
	output logic fanDrive1,
	output logic fanDrive2,
	output logic fanDrive3
);
	// refuse slow divider values the update counters cannot hold
	generate
		if (SLOW_DIV < 2 || SLOW_DIV > 256) begin : badSlowDiv
			$error("fan_opoint_ramp: SLOW_DIV must be 2..256");
		end
	endgenerate

	// software visible configuration
	logic [7:0] dynCtrl;
	logic [7:0] rampCtl1;
	logic [7:0] rampCtl2;
	logic [7:0] pwmCfg [3];
	logic [7:0] next_dynCtrl;
	logic [7:0] next_rampCtl1;
	logic [7:0] next_rampCtl2;
	logic [7:0] next_pwmCfg [3];

	// apb answer state
	logic [fan_pkg::DATA_W-1:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	// alert edge and enables state
	logic alertPrev;
	logic next_alertPrev;
	logic alertAssert;
	logic next_dynR1;
	logic next_dynLoc;
	logic next_dynR2;

	// decode helpers
	logic [fan_pkg::IDX_W-1:0] regIdx;
	logic addrOk;
	logic hit;
	logic [7:0] rdByte;
	logic setup;
	logic access;
	logic wrStb;
	logic [7:0] wrByte;

	// per channel views
	logic [7:0] tempCh [3];
	logic [7:0] opointCh [3];
	logic capEnCh [3];
	logic opWrCh [3];
	logic [7:0] opIdxCh [3];
	logic [7:0] targetCh [3];
	logic updCh [3];
	logic rampEnCh [3];
	logic [2:0] selCh [3];
	logic slowCh [3];
	logic [7:0] dutyCh [3];
	logic driveCh [3];

	// shared slot counter for the 255 slot period
	logic [7:0] slotCount;
	logic [7:0] next_slotCount;

	// channel order: 0 remote 1, 1 local, 2 remote 2
	assign tempCh[0] = tempRemote1;
	assign tempCh[1] = tempLocal;
	assign tempCh[2] = tempRemote2;
	assign opIdxCh[0] = fan_pkg::IDX_OPOINT_R1;
	assign opIdxCh[1] = fan_pkg::IDX_OPOINT_LOC;
	assign opIdxCh[2] = fan_pkg::IDX_OPOINT_R2;
	assign capEnCh[0] = dynCtrl[fan_pkg::CAP_R1_EN_BIT];
	assign capEnCh[1] = dynCtrl[fan_pkg::CAP_LOC_EN_BIT];
	assign capEnCh[2] = dynCtrl[fan_pkg::CAP_R2_EN_BIT];

	// fan outputs in order 1, 2, 3
	assign targetCh[0] = targetDuty1;
	assign targetCh[1] = targetDuty2;
	assign targetCh[2] = targetDuty3;
	assign updCh[0] = dutyUpdate1;
	assign updCh[1] = dutyUpdate2;
	assign updCh[2] = dutyUpdate3;
	assign rampEnCh[0] = rampCtl1[fan_pkg::RAMP1_EN1_BIT]; // RULE10
	assign rampEnCh[1] = rampCtl2[fan_pkg::RAMP2_EN2_BIT]; // RULE11
	assign rampEnCh[2] = rampCtl2[fan_pkg::RAMP2_EN3_BIT]; // RULE12
	// step size codes per output
	// RULE21
	assign selCh[0] = rampCtl1[fan_pkg::RAMP1_SEL1_LSB +: fan_pkg::SEL_W];
	assign selCh[1] = rampCtl2[fan_pkg::RAMP2_SEL2_LSB +: fan_pkg::SEL_W];
	assign selCh[2] = rampCtl2[fan_pkg::RAMP2_SEL3_LSB +: fan_pkg::SEL_W];

	// alert is active low; act once on its falling edge
	always_comb begin
		next_alertPrev = thermalAlertN;
		alertAssert = alertPrev && !thermalAlertN; // RULE4
	end

	// alert level memory idles high so reset makes no false edge
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			alertPrev <= 1'b1;
		end else begin
			alertPrev <= next_alertPrev;
		end
	end

	// apb address decode and read mux
	always_comb begin
		regIdx = paddr[fan_pkg::IDX_LSB +: fan_pkg::IDX_W];
		addrOk = (paddr[1:0] == 2'b00) &&
			(paddr[fan_pkg::ADDR_W-1:fan_pkg::IDX_LSB+fan_pkg::IDX_W] == '0);
		hit = addrOk;
		rdByte = 8'h00;
		case (regIdx)
			fan_pkg::IDX_DUTY1: rdByte = dutyCh[0];
			fan_pkg::IDX_DUTY2: rdByte = dutyCh[1];
			fan_pkg::IDX_DUTY3: rdByte = dutyCh[2];
			fan_pkg::IDX_DYN_CTRL1: rdByte = dynCtrl;
			fan_pkg::IDX_PWM_CFG1: rdByte = pwmCfg[0];
			fan_pkg::IDX_PWM_CFG2: rdByte = pwmCfg[1];
			fan_pkg::IDX_PWM_CFG3: rdByte = pwmCfg[2];
			fan_pkg::IDX_RAMP_CTL1: rdByte = rampCtl1;
			fan_pkg::IDX_RAMP_CTL2: rdByte = rampCtl2;
			fan_pkg::IDX_OPOINT_R1: rdByte = opointCh[0];
			fan_pkg::IDX_OPOINT_LOC: rdByte = opointCh[1];
			fan_pkg::IDX_OPOINT_R2: rdByte = opointCh[2];
			default: hit = 1'b0;
		endcase
	end

	// zero wait answer: pready rises in the first access cycle
	always_comb begin
		setup = psel && !penable;
		access = psel && penable && pready;
		wrStb = access && pwrite && !pslverr;
		wrByte = pwdata[7:0];
		next_pready = setup;
		next_pslverr = setup && !hit;
		next_prdata = prdata;
		if (setup) begin
			next_prdata = (hit && !pwrite) ?
				{24'h00_0000, rdByte} : 32'h0000_0000;
		end
	end

	// answer registers: pready and pslverr stand for one cycle
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// configuration registers written at the access edge
	always_comb begin
		next_dynCtrl = dynCtrl;
		next_rampCtl1 = rampCtl1;
		next_rampCtl2 = rampCtl2;
		for (int i = 0; i < 3; i++) begin
			next_pwmCfg[i] = pwmCfg[i];
		end
		if (wrStb) begin
			case (regIdx)
				fan_pkg::IDX_DYN_CTRL1: next_dynCtrl = wrByte;
				fan_pkg::IDX_RAMP_CTL1: next_rampCtl1 = wrByte;
				fan_pkg::IDX_RAMP_CTL2: next_rampCtl2 = wrByte;
				fan_pkg::IDX_PWM_CFG1: next_pwmCfg[0] = wrByte;
				fan_pkg::IDX_PWM_CFG2: next_pwmCfg[1] = wrByte;
				fan_pkg::IDX_PWM_CFG3: next_pwmCfg[2] = wrByte;
				default: next_dynCtrl = dynCtrl;
			endcase
		end
	end

	// configuration registers, cleared by reset
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			dynCtrl <= fan_pkg::DYN_CTRL1_RST;
			rampCtl1 <= fan_pkg::RAMP_CTL1_RST;
			rampCtl2 <= fan_pkg::RAMP_CTL2_RST;
			for (int i = 0; i < 3; i++) begin
				pwmCfg[i] <= fan_pkg::PWM_CFG_RST;
			end
		end else begin
			dynCtrl <= next_dynCtrl;
			rampCtl1 <= next_rampCtl1;
			rampCtl2 <= next_rampCtl2;
			for (int i = 0; i < 3; i++) begin
				pwmCfg[i] <= next_pwmCfg[i];
			end
		end
	end

	// dynamic minimum enables handed to the adjustment loop
	always_comb begin
		next_dynR1 = dynCtrl[fan_pkg::DYN_R1_EN_BIT]; // RULE7 RULE8 RULE9
		next_dynLoc = dynCtrl[fan_pkg::DYN_LOC_EN_BIT]; // RULE6 RULE8 RULE9
		next_dynR2 = dynCtrl[fan_pkg::DYN_R2_EN_BIT]; // RULE5 RULE8 RULE9
	end

	// enables leave the block through flip-flops
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			dynMinEnRemote1 <= 1'b0;
			dynMinEnLocal <= 1'b0;
			dynMinEnRemote2 <= 1'b0;
		end else begin
			dynMinEnRemote1 <= next_dynR1;
			dynMinEnLocal <= next_dynLoc;
			dynMinEnRemote2 <= next_dynR2;
		end
	end

	// slot counter wraps after 255 slots
	always_comb begin
		next_slotCount = (slotCount == fan_pkg::SLOT_LAST) ?
			8'h00 : slotCount + 8'h01; // RULE13
	end

	// slot counter register shared by all outputs
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			slotCount <= 8'h00;
		end else begin
			slotCount <= next_slotCount;
		end
	end

	// one capture register and one ramp limiter per channel
	generate
		for (genvar g = 0; g < 3; g++) begin : chan
			// software write strobe and slow bit for this channel
			assign opWrCh[g] = wrStb && (regIdx == opIdxCh[g]);
			assign slowCh[g] = pwmCfg[g][fan_pkg::PWM_CFG_SLOW_BIT];

			// operating point register for this channel
			fan_opoint_capture capture (
				.mclk(mclk),
				.resetn(resetn),
				.captureEn(capEnCh[g]),
				.alertAssert(alertAssert),
				.curTemp(tempCh[g]),
				.wrEn(opWrCh[g]),
				.wrData(wrByte),
				.opoint(opointCh[g])
			);

			// each output has its own ramp state
			fan_duty_ramp #(
				.SLOW_DIV(SLOW_DIV)
			) ramp (
				.mclk(mclk),
				.resetn(resetn),
				.rampEn(rampEnCh[g]),
				.stepSel(selCh[g]),
				.slowEn(slowCh[g]),
				.updateStb(updCh[g]),
				.targetDuty(targetCh[g]),
				.slotCount(slotCount),
				.duty(dutyCh[g]),
				.fanDrive(driveCh[g])
			); // RULE19
		end
	endgenerate

	// outputs straight from the channel flip-flops
	assign opointRemote1 = opointCh[0];
	assign opointLocal = opointCh[1];
	assign opointRemote2 = opointCh[2];
	assign fanDuty1 = dutyCh[0];
	assign fanDuty2 = dutyCh[1];
	assign fanDuty3 = dutyCh[2];
	assign fanDrive1 = driveCh[0];
	assign fanDrive2 = driveCh[1];
	assign fanDrive3 = driveCh[2];
endmodule : fan_opoint_ramp

// ==== include/fan_pkg.sv ====
// shared constants for the fan operating point and duty ramp block
package fan_pkg;
	// apb geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int IDX_W = 8;
	localparam int IDX_LSB = 2;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_DUTY1 = 8'h30;
	localparam logic [7:0] IDX_DUTY2 = 8'h31;
	localparam logic [7:0] IDX_DUTY3 = 8'h32;
	localparam logic [7:0] IDX_DYN_CTRL1 = 8'h36;
	localparam logic [7:0] IDX_PWM_CFG1 = 8'h5C;
	localparam logic [7:0] IDX_PWM_CFG2 = 8'h5D;
	localparam logic [7:0] IDX_PWM_CFG3 = 8'h5E;
	localparam logic [7:0] IDX_RAMP_CTL1 = 8'h62;
	localparam logic [7:0] IDX_RAMP_CTL2 = 8'h63;
	localparam logic [7:0] IDX_OPOINT_R1 = 8'h80;
	localparam logic [7:0] IDX_OPOINT_LOC = 8'h81;
	localparam logic [7:0] IDX_OPOINT_R2 = 8'h82;

	// dynamic control register 1 fields
	localparam int DYN_R2_EN_BIT = 7;
	localparam int DYN_LOC_EN_BIT = 6;
	localparam int DYN_R1_EN_BIT = 5;
	localparam int CAP_R2_EN_BIT = 4;
	localparam int CAP_LOC_EN_BIT = 3;
	localparam int CAP_R1_EN_BIT = 2;

	// acoustic and pwm configuration register fields
	localparam int SEL_W = 3;
	localparam int RAMP1_SEL1_LSB = 0;
	localparam int RAMP1_EN1_BIT = 3;
	localparam int RAMP2_SEL3_LSB = 0;
	localparam int RAMP2_EN3_BIT = 3;
	localparam int RAMP2_SEL2_LSB = 4;
	localparam int RAMP2_EN2_BIT = 7;
	localparam int PWM_CFG_SLOW_BIT = 3;

	// reset values
	localparam logic [7:0] DYN_CTRL1_RST = 8'h00;
	localparam logic [7:0] RAMP_CTL1_RST = 8'h00;
	localparam logic [7:0] RAMP_CTL2_RST = 8'h00;
	localparam logic [7:0] PWM_CFG_RST = 8'h00;
	localparam logic [7:0] OPOINT_RST = 8'h00;
	localparam logic [7:0] DUTY_RST = 8'h00;

	// duty period of 255 slots, counter runs 0..254
	localparam logic [7:0] DUTY_MAX = 8'hFF;
	localparam logic [7:0] SLOT_LAST = 8'hFE;
	localparam int SLOW_FACTOR = 4;

	// ramp step in slots for each selector code 000..111
	localparam logic [7:0] STEP_TABLE [8] = '{
		8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30
	};
endpackage : fan_pkg

// ==== src/fan_opoint_capture.sv ====
// one operating point register, loaded by software or by a thermal alert
`timescale 1ns/1ps
module fan_opoint_capture (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic captureEn,
	input wire logic alertAssert,
	input wire logic [7:0] curTemp,
	input wire logic wrEn,
	input wire logic [7:0] wrData,
	output logic [7:0] opoint
);
	logic [7:0] next_opoint;

	// capture beats a software write in the same cycle
	always_comb begin
		next_opoint = opoint;
		if (wrEn) begin
			next_opoint = wrData;
		end
		if (captureEn && alertAssert) begin
			next_opoint = curTemp; // RULE1 RULE2 RULE3
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			opoint <= fan_pkg::OPOINT_RST;
		end else begin
			opoint <= next_opoint;
		end
	end
endmodule : fan_opoint_capture

// ==== src/fan_duty_ramp.sv ====
// per output duty ramp limiter and slot comparator
`timescale 1ns/1ps
module fan_duty_ramp #(
	parameter int SLOW_DIV = fan_pkg::SLOW_FACTOR
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic rampEn,
	input wire logic [2:0] stepSel,
	input wire logic slowEn,
	input wire logic updateStb,
	input wire logic [7:0] targetDuty,
	input wire logic [7:0] slotCount,
	output logic [7:0] duty,
	output logic fanDrive
);
	localparam int CW = (SLOW_DIV > 1) ? $clog2(SLOW_DIV) : 1;
	localparam logic [CW-1:0] SLOW_LAST = CW'(SLOW_DIV - 1);

	generate
		if (SLOW_DIV < 2 || SLOW_DIV > 256) begin : badSlowDiv
			$error("fan_duty_ramp: SLOW_DIV must be 2..256");
		end
	endgenerate

	logic [CW-1:0] slowCnt;
	logic [CW-1:0] next_slowCnt;
	logic [7:0] next_duty;
	logic next_fanDrive;
	logic [7:0] step;
	logic [8:0] upSum;
	logic applyStep;

	// ramp decision on each duty update
	always_comb begin
		step = fan_pkg::STEP_TABLE[stepSel]; // RULE14 RULE21
		upSum = {1'b0, duty} + {1'b0, step};
		applyStep = !slowEn || (slowCnt == SLOW_LAST); // RULE22
		next_slowCnt = slowCnt;
		next_duty = duty;
		if (updateStb) begin
			if (!rampEn) begin
				next_duty = targetDuty; // RULE20
			end else begin
				if (slowEn) begin
					next_slowCnt = applyStep ? '0 : slowCnt + 1'b1;
				end
				if (applyStep) begin
					if (targetDuty > duty) begin
						// RULE15 RULE16 RULE23
						next_duty = upSum[8] ? fan_pkg::DUTY_MAX : upSum[7:0];
					end else if (targetDuty < duty) begin
						// RULE17 RULE23
						next_duty = (duty < step) ? 8'h00 : duty - step;
					end
				end
			end
		end
		// high for duty slots out of 255
		next_fanDrive = (slotCount < duty); // RULE13
	end

	// duty is kept as the previous value for the next compare
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			duty <= fan_pkg::DUTY_RST;
			slowCnt <= '0;
			fanDrive <= 1'b0;
		end else begin
			duty <= next_duty; // RULE18
			slowCnt <= next_slowCnt;
			fanDrive <= next_fanDrive;
		end
	end
endmodule : fan_duty_ramp

// ==== tb/thermal_trip_model.sv ====
// processor side that pulls the thermal alert low on a trip
`timescale 1ns/1ps
module thermal_trip_model (
	input wire logic mclk,
	input wire logic trip,
	output logic thermalAlertN = 1'b1
);
	// alert follows the monitor trip, low while tripped
	always @(posedge mclk) begin
		thermalAlertN <= !trip;
	end
endmodule : thermal_trip_model

// ==== tb/fan_opoint_ramp_chk.sv ====
// assertion checker for the fan operating point and duty ramp block
`timescale 1ns/1ps
module fan_opoint_ramp_chk #(
	parameter int SLOW_DIV = 4
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic thermalAlertN,
	input wire logic [7:0] tempRemote1,
	input wire logic [7:0] tempLocal,
	input wire logic [7:0] tempRemote2,
	input wire logic [7:0] targetDuty1,
	input wire logic dutyUpdate1,
	input wire logic [7:0] opointRemote1,
	input wire logic [7:0] opointLocal,
	input wire logic [7:0] opointRemote2,
	input wire logic dynMinEnRemote2,
	input wire logic [7:0] fanDuty1,
	input wire logic fanDrive1
);
	logic [7:0] ctl, rampCtl, cfg;
	logic [8:0] up;
	logic wr;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	// shadows of the control bytes, taken on accepted writes
	assign wr = psel && penable && pready && pwrite && !pslverr;
	assign up = 9'(fanDuty1) + 9'(fan_pkg::STEP_TABLE[rampCtl[2:0]]);
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctl <= 8'h00;
			rampCtl <= 8'h00;
			cfg <= 8'h00;
		end else if (wr) begin
			if (paddr == 12'h0d8) ctl <= pwdata[7:0];
			if (paddr == 12'h188) rampCtl <= pwdata[7:0];
			if (paddr == 12'h170) cfg <= pwdata[7:0];
		end
	end
	property p_capR1;
		$fell(thermalAlertN) && ctl[2] |=> opointRemote1 == $past(tempRemote1);
	endproperty
	a_capR1: assert property (p_capR1) else $error("no capture r1");
	property p_capLoc;
		$fell(thermalAlertN) && ctl[3] |=> opointLocal == $past(tempLocal);
	endproperty
	a_capLoc: assert property (p_capLoc) else $error("no capture l");
	property p_capR2;
		$fell(thermalAlertN) && ctl[4] |=> opointRemote2 == $past(tempRemote2);
	endproperty
	a_capR2: assert property (p_capR2) else $error("no capture r2");
	property p_noCap;
		$fell(thermalAlertN) && !ctl[4] && !wr |=> $stable(opointRemote2);
	endproperty
	a_noCap: assert property (p_noCap) else $error("stray capture");
	property p_dyn;
		$changed(ctl[7]) |-> ##[0:1] dynMinEnRemote2 == ctl[7];
	endproperty
	a_dyn: assert property (p_dyn) else $error("dyn enable");
	property p_noRamp;
		dutyUpdate1 && !rampCtl[3] |=> fanDuty1 == $past(targetDuty1);
	endproperty
	a_noRamp: assert property (p_noRamp) else $error("no ramp");
	property p_up;
		dutyUpdate1 && rampCtl[3] && !cfg[3] && targetDuty1 > fanDuty1
		|=> fanDuty1 == ($past(up[8]) ? 8'hff : $past(up[7:0]));
	endproperty
	a_up: assert property (p_up) else $error("ramp up");
	property p_down;
		dutyUpdate1 && rampCtl[3] && !cfg[3] && targetDuty1 < fanDuty1
		|=> fanDuty1 < $past(fanDuty1);
	endproperty
	a_down: assert property (p_down) else $error("ramp down");
	property p_drive;
		$stable(fanDuty1) && (fanDuty1 == 8'h00 || fanDuty1 == 8'hff)
		|-> fanDrive1 == fanDuty1[0];
	endproperty
	a_drive: assert property (p_drive) else $error("drive level");
	property p_apb;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_apb: assert property (p_apb) else $error("apb answer");
endmodule : fan_opoint_ramp_chk

// ==== tb/fan_opoint_ramp_bench.sv ====
// testbench for the fan operating point and duty ramp block
`timescale 1ns/1ps
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin \
	bad_count++; $display("Error %0t: got %h want %h", $time, g, x); end end
module fan_opoint_ramp_bench;
	localparam int SLOW_DIV = 4;
	logic mclk = 1'b0, resetn = 1'b0, trip = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
	logic pready, pslverr, thermalAlertN, rerr;
	logic [7:0] tempRemote1 = 8'h31, tempLocal = 8'h42, tempRemote2 = 8'h53;
	logic [7:0] targetDuty1 = 8'h00, targetDuty2 = 8'h00, targetDuty3 = 8'h00;
	logic dutyUpdate1 = 1'b0, dutyUpdate2 = 1'b0, dutyUpdate3 = 1'b0;
	logic [7:0] opointRemote1, opointLocal, opointRemote2;
	logic dynMinEnRemote1, dynMinEnLocal, dynMinEnRemote2;
	logic [7:0] fanDuty1, fanDuty2, fanDuty3;
	logic fanDrive1, fanDrive2, fanDrive3;
	int bad_count = 0, samples_checked = 0, n, n2, n3;
	logic [11:0] regs [4] = '{12'h0d8, 12'h188, 12'h18c, 12'h170};
	fan_opoint_ramp #(.SLOW_DIV(SLOW_DIV)) uut (
		.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .thermalAlertN, .tempRemote1, .tempLocal,
		.tempRemote2, .targetDuty1, .targetDuty2, .targetDuty3, .dutyUpdate1,
		.dutyUpdate2, .dutyUpdate3, .opointRemote1, .opointLocal,
		.opointRemote2, .dynMinEnRemote1, .dynMinEnLocal, .dynMinEnRemote2,
		.fanDuty1, .fanDuty2, .fanDuty3, .fanDrive1, .fanDrive2, .fanDrive3
	);
	thermal_trip_model proc (.mclk, .trip, .thermalAlertN);
	// free running 10 MHz clock
	always #50 mclk = ~mclk;
	// prints the counts and the verdict, then stops
	task automatic results();
		$display("compared %0d mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	// one apb transfer, held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
		if (n >= 20) begin
			bad_count++;
			results();
		end
	endtask : apb
	// one update pulse on the selected outputs, then let it land
	task automatic upd(input logic [2:0] m, input logic [7:0] t);
		targetDuty1 <= t;
		targetDuty2 <= t;
		targetDuty3 <= t;
		{dutyUpdate3, dutyUpdate2, dutyUpdate1} <= m;
		@(posedge mclk);
		{dutyUpdate3, dutyUpdate2, dutyUpdate1} <= 3'b000;
		@(posedge mclk);
	endtask : upd
	// watchdog against a hung handshake
	initial begin
		#500_000;
		bad_count++;
		results();
	end
	// main sequence
	initial begin
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		foreach (regs[i]) begin
			apb(1'b0, regs[i], 32'h0000_0000);
			`CHK(rdat, 32'h0000_0000)
		end
		apb(1'b0, 12'h004, 32'h0000_0000);
		`CHK(rerr, 1'b1)
		$display("test registers done");
		apb(1'b1, 12'h208, 32'h0000_005a);
		apb(1'b1, 12'h0d8, 32'h0000_000c);
		trip <= 1'b1;
		repeat (3) @(posedge mclk);
		`CHK(opointRemote1, 8'h31)
		`CHK(opointLocal, 8'h42)
		`CHK(opointRemote2, 8'h5a)
		trip <= 1'b0;
		tempRemote1 <= 8'h75;
		tempRemote2 <= 8'h64;
		apb(1'b1, 12'h0d8, 32'h0000_0010);
		trip <= 1'b1;
		repeat (3) @(posedge mclk);
		`CHK(opointRemote2, 8'h64)
		`CHK(opointRemote1, 8'h31)
		trip <= 1'b0;
		apb(1'b1, 12'h0d8, 32'h0000_00e0);
		@(posedge mclk);
		`CHK(dynMinEnRemote2, 1'b1)
		`CHK(dynMinEnLocal, 1'b1)
		`CHK(dynMinEnRemote1, 1'b1)
		apb(1'b0, 12'h0d8, 32'h0000_0000);
		`CHK(rdat, 32'h0000_00e0)
		apb(1'b0, 12'h208, 32'h0000_0000);
		`CHK(rdat, 32'h0000_0064)
		$display("test capture done");
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, 12'h188, 32'h0000_0000);
			upd(3'b001, 8'h00);
			apb(1'b1, 12'h188, 32'(8 + c));
			upd(3'b001, 8'hff);
			`CHK(fanDuty1, fan_pkg::STEP_TABLE[c])
			upd(3'b001, 8'hff);
			`CHK(fanDuty1, 8'(2 * fan_pkg::STEP_TABLE[c]))
			upd(3'b001, 8'h00);
			`CHK(fanDuty1, fan_pkg::STEP_TABLE[c])
		end
		$display("test steps done");
		apb(1'b1, 12'h188, 32'h0000_0000);
		apb(1'b1, 12'h18c, 32'h0000_00b8);
		upd(3'b111, 8'hc8);
		`CHK(fanDuty1, 8'hc8)
		`CHK(fanDuty2, 8'h05)
		`CHK(fanDuty3, 8'h01)
		apb(1'b0, 12'h0c4, 32'h0000_0000);
		`CHK(rdat, 32'h0000_0005)
		apb(1'b1, 12'h178, 32'h0000_0008);
		repeat (4) upd(3'b100, 8'hc8);
		`CHK(fanDuty3, 8'(1 + 4 / SLOW_DIV))
		$display("test outputs done");
		upd(3'b001, 8'hfa);
		apb(1'b1, 12'h188, 32'h0000_000f);
		upd(3'b001, 8'hfa);
		`CHK(fanDuty1, 8'hfa)
		upd(3'b001, 8'hff);
		`CHK(fanDuty1, 8'hff)
		apb(1'b1, 12'h188, 32'h0000_0000);
		upd(3'b001, 8'h55);
		@(posedge mclk);
		n = 0;
		n2 = 0;
		n3 = 0;
		repeat (255) begin
			@(posedge mclk);
			if (fanDrive1 === 1'b1) n++;
			if (fanDrive2 === 1'b1) n2++;
			if (fanDrive3 === 1'b1) n3++;
		end
		`CHK(n, 85)
		`CHK(n2, 5)
		`CHK(n3, 1 + 4 / SLOW_DIV)
		$display("test slots done");
		results();
	end
endmodule : fan_opoint_ramp_bench
bind fan_opoint_ramp fan_opoint_ramp_chk #(.SLOW_DIV(SLOW_DIV)) chk (
	.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.pslverr, .thermalAlertN, .tempRemote1, .tempLocal, .tempRemote2,
	.targetDuty1, .dutyUpdate1, .opointRemote1, .opointLocal,
	.opointRemote2, .dynMinEnRemote2, .fanDuty1, .fanDrive1
);
